// >>> urx_map.vh
// Register map, field positions and reset values for the serial receiver.
// Included by the receiver module; definitions only.
`ifndef URX_MAP_VH
`define URX_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define URX_ADDR_W          2
`define URX_OFF_DATA        2'h0
`define URX_OFF_STATUS      2'h1
`define URX_OFF_CTRL_B      2'h2
`define URX_OFF_CTRL_C      2'h3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define URX_ST_RXC          7
`define URX_ST_FE           4
`define URX_ST_DOR          3
`define URX_ST_PE           2
`define URX_ST_U2X          1

// ----------------------------------------------------------------
// Control register b fields
// ----------------------------------------------------------------
`define URX_CB_RXCIE        7
`define URX_CB_RXEN         4
`define URX_CB_CHR9         2
`define URX_CB_RXB8         1

// ----------------------------------------------------------------
// Control register c fields
// ----------------------------------------------------------------
`define URX_CC_PAR_EN       5
`define URX_CC_PAR_ODD      4
`define URX_CC_STOP2        3
`define URX_CC_CSZ_HI       2
`define URX_CC_CSZ_LO       1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define URX_RST_STATUS      8'h00
`define URX_RST_CTRL_B      8'h00
`define URX_RST_CTRL_C      8'h06
`define URX_SPB_NORMAL      5'h10
`define URX_SPB_DOUBLE      5'h08
`define URX_BAUD_DIV_RST    12'h000

`endif

// >>> urx_vote.v
// Three-sample majority voter for one bit period.
// Assumes samples arrive as a same-clock strobe with the line level.
`timescale 1ns/100ps
`default_nettype none

module urx_vote (
    // Clock and reset
    input  wire       clk_in,
    input  wire       reset_n_in,
    // Control
    input  wire       clear_in,
    input  wire       take_in,
    input  wire       line_in,
    // Result
    output wire       bit_out
);

    reg [1:0] hist_r;

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hist_r <= 2'h3;
        end else if (clear_in) begin
            hist_r <= 2'h3;
        end else if (take_in) begin
            hist_r <= {hist_r[0], line_in};
        end
    end

    // Majority of the two held samples and the current one
    assign bit_out = (hist_r[1] & hist_r[0]) | (hist_r[1] & line_in) |
                     (hist_r[0] & line_in);

endmodule

`default_nettype wire

// >>> urx_receiver.v
// Serial receiver: start detect, data recovery, two-deep buffer, status.
// Assumes a same-clock register port and an asynchronous receive pin.
// Contract
// [RQ1] Complete flag high iff buffer holds data
// [RQ2] Clearing enable flushes buffer
// [RQ3] Interrupt request is level while flag set
// [RQ4] Error flags buffered with each character
// [RQ5] Software writes to error flags ignored
// [RQ6] Error flags raise no interrupt
// [RQ7] Frame error set when stop is zero
// [RQ8] Only first stop bit examined
// [RQ9] Overrun on full buffer, waiting char, start
// [RQ10] Overrun cleared on successful transfer
// [RQ11] Parity error reads zero when disabled
// [RQ12] Upper bit enables parity, lower picks type
// [RQ13] Parity result stored only if enabled then
// [RQ14] Disable is immediate; pin released
// [RQ15] Sample at sixteen or eight per bit
// [RQ16] First low sample is one; vote centre
// [RQ17] Majority high rejects start as noise
// [RQ18] Software reads status before data
// [RQ19] Software writes zero to error positions
// [RQ20] Software flushes by reading until empty
// [RQ21] Ninth bit buffered with its character
// [RQ22] Each bit decided by centre majority
// [RQ23] Lower bit zero even, one odd
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

`include "urx_map.vh"

module urx_receiver #(
    parameter BAUD_DIV_W = 12
) (
    // Clock and reset
    input  wire                   clk_in,
    input  wire                   reset_n_in,
    // Register port
    input  wire [`URX_ADDR_W-1:0] addr_in,
    input  wire [7:0]             wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [7:0]             rdata_out,
    // Sample rate divider (sample tick every div+1 clocks)
    input  wire [BAUD_DIV_W-1:0]  baud_div_in,
    // Serial line
    input  wire                   rxd_in,
    output wire                   rxd_override_out,
    // Interrupt request
    output wire                   rx_irq_out
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam ST_IDLE  = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_BITS  = 2'h2;

    // ----------------------------------------------------------------
    // Registers and line synchroniser
    // ----------------------------------------------------------------
    reg                  rxd_s1_r;
    reg                  rxd_s2_r;
    reg                  rxd_prev_r;
    reg [7:0]            ctrl_b_r;
    reg [7:0]            ctrl_c_r;
    reg                  double_speed_r;
    reg [BAUD_DIV_W-1:0] div_cnt_r;
    reg [1:0]            state_r;
    reg [4:0]            samp_r;
    reg [3:0]            bit_idx_r;
    reg [8:0]            shift_r;
    reg                  par_bit_r;
    reg                  hold_valid_r;
    reg [11:0]           hold_r;
    reg                  hold_dor_r;
    reg [11:0]           buf_r [0:1];
    reg [1:0]            count_r;
    reg                  rd_ptr_r;
    reg                  dor_pending_r;

    wire receiver_enable_bit = ctrl_b_r[`URX_CB_RXEN];
    wire parity_enable_bit   = ctrl_c_r[`URX_CC_PAR_EN];
    wire parity_odd_select   = ctrl_c_r[`URX_CC_PAR_ODD];
    // Gated by enable so a disable hides stale data in the same cycle
    wire rx_complete_flag    = receiver_enable_bit && (count_r != 2'h0);
    wire sample_tick         = (div_cnt_r == {BAUD_DIV_W{1'b0}});
    wire [4:0] spb = double_speed_r ? `URX_SPB_DOUBLE : `URX_SPB_NORMAL;
    wire [4:0] half = {1'b0, spb[4:1]};
    wire [3:0] dbits = ctrl_b_r[`URX_CB_CHR9] ? 4'h9 :
                       (4'h5 + {2'h0, ctrl_c_r[`URX_CC_CSZ_HI],
                                ctrl_c_r[`URX_CC_CSZ_LO]});
    wire [3:0] last_idx = dbits + {3'h0, parity_enable_bit};
    wire       voted;
    // [RQ16] [RQ22] centre samples voted
    wire       vote_take = sample_tick && (samp_r == half ||
                                           samp_r == half + 5'h1);
    wire       decide    = sample_tick && (samp_r == half + 5'h2);
    wire       rd_data   = rd_in && addr_in == `URX_OFF_DATA;
    wire       buf_full  = (count_r == 2'h2);
    wire       pop       = rd_data && rx_complete_flag;
    wire [11:0] head     = buf_r[rd_ptr_r];

    // [RQ14] pin released
    assign rxd_override_out = receiver_enable_bit;
    // [RQ3] level request, [RQ6] errors excluded
    assign rx_irq_out = ctrl_b_r[`URX_CB_RXCIE] & rx_complete_flag;

    // [RQ22] centre majority
    urx_vote u_vote (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .clear_in   (state_r == ST_IDLE),
        .take_in    (vote_take),
        .line_in    (rxd_s2_r),
        .bit_out    (voted)
    );

    // ----------------------------------------------------------------
    // Synchroniser and sample divider
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rxd_s1_r   <= 1'b1;
            rxd_s2_r   <= 1'b1;
            rxd_prev_r <= 1'b1;
            div_cnt_r  <= `URX_BAUD_DIV_RST;
        end else begin
            rxd_s1_r <= rxd_in;
            rxd_s2_r <= rxd_s1_r;
            if (sample_tick) begin
                rxd_prev_r <= rxd_s2_r;
                div_cnt_r  <= baud_div_in;
            end else begin
                div_cnt_r <= div_cnt_r - {{(BAUD_DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_b_r       <= `URX_RST_CTRL_B;
            ctrl_c_r       <= `URX_RST_CTRL_C;
            double_speed_r <= 1'b0;
        end else if (wr_in) begin
            case (addr_in)
                `URX_OFF_CTRL_B: ctrl_b_r <= wdata_in;
                `URX_OFF_CTRL_C: ctrl_c_r <= wdata_in;
                // [RQ5] only mode bit writable
                `URX_OFF_STATUS:
                    double_speed_r <= wdata_in[`URX_ST_U2X];
                default: ctrl_b_r <= ctrl_b_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Start detection and data recovery
    // ----------------------------------------------------------------
    wire par_calc = ^shift_r;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r      <= ST_IDLE;
            samp_r       <= 5'h00;
            bit_idx_r    <= 4'h0;
            shift_r      <= 9'h000;
            par_bit_r    <= 1'b0;
            hold_valid_r <= 1'b0;
            hold_r       <= 12'h000;
            hold_dor_r   <= 1'b0;
        end else if (!receiver_enable_bit) begin
            // [RQ14] abandon frame
            state_r      <= ST_IDLE;
            hold_valid_r <= 1'b0;
            hold_dor_r   <= 1'b0;
        end else begin
            // [RQ10] transfer clears overrun
            if (hold_valid_r && !buf_full) begin
                hold_valid_r <= 1'b0;
                hold_dor_r   <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    // [RQ16] first low sample is one
                    if (sample_tick && rxd_prev_r && !rxd_s2_r) begin
                        state_r <= ST_START;
                        samp_r  <= 5'h2;
                    end
                end
                ST_START: begin
                    if (sample_tick) begin
                        samp_r <= samp_r + 5'h1;
                        if (decide) begin
                            // [RQ17] noise rejection
                            if (voted) begin
                                state_r <= ST_IDLE;
                            end else begin
                                state_r   <= ST_BITS;
                                bit_idx_r <= 4'h0;
                                shift_r   <= 9'h000;
                                // [RQ9] overrun on next start
                                if (hold_valid_r && buf_full)
                                    hold_dor_r <= 1'b1;
                            end
                        end
                        if (samp_r == spb)
                            samp_r <= 5'h1;
                    end
                end
                ST_BITS: begin
                    if (sample_tick) begin
                        samp_r <= (samp_r == spb) ? 5'h1 : samp_r + 5'h1;
                        if (decide && samp_r != 5'h0) begin
                            bit_idx_r <= bit_idx_r + 4'h1;
                            if (bit_idx_r < dbits)
                                shift_r[bit_idx_r] <= voted;
                            else if (bit_idx_r < last_idx)
                                par_bit_r <= voted;
                            else begin
                                // [RQ8] first stop only
                                state_r      <= ST_IDLE;
                                hold_valid_r <= 1'b1;
                                // [RQ7] stop zero is frame error
                                // [RQ13] stored only if enabled
                                // [RQ12] [RQ23] even or odd check
                                hold_r <= {~voted,
                                    parity_enable_bit &
                                    (par_calc ^ par_bit_r ^
                                     parity_odd_select),
                                    1'b0, shift_r};
                            end
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Two-deep receive buffer
    // ----------------------------------------------------------------
    wire push = receiver_enable_bit && hold_valid_r && !buf_full;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_r       <= 2'h0;
            rd_ptr_r      <= 1'b0;
            dor_pending_r <= 1'b0;
            buf_r[0]      <= 12'h000;
            buf_r[1]      <= 12'h000;
        end else if (!receiver_enable_bit) begin
            // [RQ2] flush on disable
            count_r  <= 2'h0;
            rd_ptr_r <= 1'b0;
        end else begin
            if (push) begin
                // [RQ4] [RQ21] flags and ninth bit stored
                buf_r[rd_ptr_r ^ count_r[0]] <=
                    {hold_r[11:10], hold_dor_r, hold_r[8:0]};
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            // [RQ1] count tracks unread characters
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `URX_OFF_DATA: rdata_out <= head[7:0];
                `URX_OFF_STATUS: begin
                    rdata_out <= `URX_RST_STATUS;
                    rdata_out[`URX_ST_RXC] <= rx_complete_flag;
                    rdata_out[`URX_ST_FE]  <= rx_complete_flag & head[11];
                    rdata_out[`URX_ST_DOR] <= rx_complete_flag & head[9];
                    // [RQ11] zero when parity disabled
                    rdata_out[`URX_ST_PE]  <= rx_complete_flag &
                                              head[10] & parity_enable_bit;
                    rdata_out[`URX_ST_U2X] <= double_speed_r;
                end
                `URX_OFF_CTRL_B: rdata_out <= {ctrl_b_r[7:2],
                    head[8], ctrl_b_r[0]};
                default: rdata_out <= ctrl_c_r;
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> urx_line_drv.sv
// Remote serial transmitter model driving the receive line.
// Assumes bit times are whole cycles of the shared clock.
`timescale 1ns/100ps
`default_nettype none

module urx_line_drv (
    // Clock and line
    input  wire logic clk_in,
    output var  logic line_out
);
    // Released line rests high on its pull-up
    initial line_out = 1'b1;

    task automatic hold(input logic v, input int n);
        line_out <= v;
        repeat (n) @(posedge clk_in);
    endtask

    // Start, data lsb first, parity when p >= 0, stop, one idle bit
    task automatic send(input logic [8:0] d, input int nb, bt, p,
                        input logic stp);
        int i;
        @(posedge clk_in);
        hold(1'b0, bt);
        for (i = 0; i < nb; i++) begin
            hold(d[i], bt);
        end
        if (p >= 0) begin
            hold(p[0], bt);
        end
        hold(stp, bt);
        hold(1'b1, bt);
    endtask

    // Low pulse of n cycles, then idle long enough for any frame
    task automatic glitch(input int n);
        @(posedge clk_in);
        hold(1'b0, n);
        hold(1'b1, 200);
    endtask
endmodule

`default_nettype wire

// >>> urx_receiver_sva.sv
// Port-level assertions for the serial receiver.
// Assumes control reaches the block only through its register port.
`timescale 1ns/100ps
`default_nettype none

module urx_receiver_sva #(
    parameter BAUD_DIV_W = 12
) (
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic [1:0]            addr_in,
    input  wire logic [7:0]            wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    input  wire logic [7:0]            rdata_out,
    input  wire logic [BAUD_DIV_W-1:0] baud_div_in,
    input  wire logic                  rxd_in,
    input  wire logic                  rxd_override_out,
    input  wire logic                  rx_irq_out
);
    // Shadows of the writable control bits
    logic [7:0] cb_r;
    logic [7:0] cc_r;
    logic       u2x_r;
    logic       rd_st;
    logic       rd_dat;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cb_r  <= 8'h00;
            cc_r  <= 8'h06;
            u2x_r <= 1'b0;
        end else if (wr_in) begin
            if (addr_in == 2'h2) cb_r <= wdata_in;
            if (addr_in == 2'h3) cc_r <= wdata_in;
            if (addr_in == 2'h1) u2x_r <= wdata_in[1];
        end
    end

    assign rd_st  = rd_in && addr_in == 2'h1;
    assign rd_dat = rd_in && addr_in == 2'h0;

    default clocking dclk @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    chk_pin_release: assert property (rxd_override_out == cb_r[4])
        else $error("pin ownership differs from receiver enable");
    chk_irq_gate: assert property (rx_irq_out |-> cb_r[7] && cb_r[4])
        else $error("interrupt request without enable");
    chk_irq_level: assert property
        (rx_irq_out && !rd_dat && !wr_in |=> rx_irq_out)
        else $error("interrupt request dropped without a read");
    chk_rxc_irq: assert property
        (rd_st && cb_r[7] |=> rdata_out[7] == $past(rx_irq_out))
        else $error("complete flag disagrees with interrupt request");
    chk_flush_off: assert property
        (rd_st && !cb_r[4] |=> !rdata_out[7])
        else $error("complete flag set while receiver disabled");
    chk_pe_off: assert property (rd_st && !cc_r[5] |=> !rdata_out[2])
        else $error("parity error reads one with checking off");
    chk_u2x_back: assert property (rd_st |=> rdata_out[1] == u2x_r)
        else $error("double speed bit reads back wrong");
    chk_rd_hold: assert property (!rd_in |=> $stable(rdata_out))
        else $error("read data changed without a read");

    cover property ($rose(rx_irq_out));
    cover property (rd_st ##1 rdata_out[3]);
    cover property (rd_st ##1 rdata_out[4]);
endmodule

`default_nettype wire

// >>> urx_receiver_test.sv
// Self-checking bench for the serial receiver.
// Assumes the line model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
    end \
end

module urx_receiver_test;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [1:0]  addr_in = 2'h0;
    logic [7:0]  wdata_in = 8'h00;
    logic [11:0] baud_div_in = 12'h000;
    logic [7:0]  v;
    wire  [7:0]  rdata_out;
    wire         rxd_in;
    wire         rxd_override_out;
    wire         rx_irq_out;
    int          failures = 0;
    int          checks = 0;
    int          i;

    // Sample tick every clock: 16 cycles per bit, 8 at double speed
    urx_receiver dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .baud_div_in(baud_div_in),
        .rxd_in(rxd_in), .rxd_override_out(rxd_override_out),
        .rx_irq_out(rx_irq_out));
    urx_line_drv u (.clk_in(clk_in), .line_out(rxd_in));

    always #5 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Register port tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    // Answer is looked at just after the edge that registers it; it holds until the next read
    task automatic rdv(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    task automatic ex(input logic [1:0] a, input logic [7:0] m, e);
        logic [7:0] d;
        rdv(a, d);
        `CHK(d & m, e)
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_frame;
        ex(2'h1, 8'hff, 8'h00);
        ex(2'h3, 8'hff, 8'h06);
        `CHK(rxd_override_out, 1'b0)
        wr(2'h2, 8'h90);
        wr(2'h3, 8'h0e);
        u.send(9'h0a5, 8, 16, -1, 1'b1);
        u.send(9'h05a, 8, 16, -1, 1'b0);
        `CHK(rx_irq_out, 1'b1)
        ex(2'h1, 8'h9c, 8'h80);
        wr(2'h1, 8'h00);
        ex(2'h0, 8'hff, 8'ha5);
        ex(2'h1, 8'h9c, 8'h90);
        wr(2'h1, 8'h00);
        ex(2'h1, 8'h9c, 8'h90);
        // Frame error pending, complete interrupt off: no request
        wr(2'h2, 8'h10);
        @(negedge clk_in);
        `CHK(rx_irq_out, 1'b0)
        wr(2'h2, 8'h90);
        ex(2'h0, 8'hff, 8'h5a);
        wr(2'h1, 8'h1c);
        ex(2'h1, 8'h9c, 8'h00);
        `CHK(rx_irq_out, 1'b0)
        wr(2'h3, 8'h06);
        $display("frame test done");
    endtask

    task automatic t_parity;
        for (i = 0; i < 4; i++) begin
            wr(2'h3, {2'b00, 1'b1, i[1], 4'h6});
            u.send(9'h001, 8, 16, i[0], 1'b1);
            ex(2'h1, 8'h9c, {5'h10, i[0] ^ ~i[1], 2'b00});
            ex(2'h0, 8'hff, 8'h01);
        end
        wr(2'h3, 8'h26);
        u.send(9'h001, 8, 16, 0, 1'b1);
        wr(2'h3, 8'h06);
        ex(2'h1, 8'h9c, 8'h80);
        ex(2'h0, 8'hff, 8'h01);
        u.send(9'h003, 8, 16, -1, 1'b1);
        wr(2'h3, 8'h26);
        ex(2'h1, 8'h9c, 8'h80);
        ex(2'h0, 8'hff, 8'h03);
        wr(2'h3, 8'h06);
        $display("parity test done");
    endtask

    task automatic t_overrun;
        for (i = 1; i < 5; i++) begin
            u.send(9'(i * 17), 8, 16, -1, 1'b1);
        end
        `CHK(rx_irq_out, 1'b1)
        ex(2'h1, 8'h9c, 8'h80);
        ex(2'h0, 8'hff, 8'h11);
        ex(2'h1, 8'h9c, 8'h80);
        ex(2'h0, 8'hff, 8'h22);
        // The waiting third character was lost to the fourth
        ex(2'h1, 8'h9c, 8'h88);
        ex(2'h0, 8'hff, 8'h44);
        u.send(9'h066, 8, 16, -1, 1'b1);
        u.send(9'h077, 8, 16, -1, 1'b1);
        // drain by reading data while the flag is up
        repeat (4) begin
            rdv(2'h1, v);
            if (v[7]) rdv(2'h0, v);
        end
        ex(2'h1, 8'h9c, 8'h00);
        u.send(9'h055, 8, 16, -1, 1'b1);
        ex(2'h1, 8'h9c, 8'h80);
        ex(2'h0, 8'hff, 8'h55);
        $display("overrun test done");
    endtask

    task automatic t_ninth;
        wr(2'h2, 8'h94);
        u.send(9'h1a5, 9, 16, -1, 1'b1);
        u.send(9'h05a, 9, 16, -1, 1'b1);
        ex(2'h2, 8'h02, 8'h02);
        ex(2'h0, 8'hff, 8'ha5);
        ex(2'h2, 8'h02, 8'h00);
        ex(2'h0, 8'hff, 8'h5a);
        wr(2'h2, 8'h90);
        $display("ninth bit test done");
    endtask

    task automatic t_noise;
        u.glitch(8);
        ex(2'h1, 8'h9c, 8'h00);
        u.glitch(10);
        ex(2'h1, 8'h9c, 8'h80);
        ex(2'h0, 8'hff, 8'hff);
        wr(2'h1, 8'h02);
        u.glitch(4);
        ex(2'h1, 8'h9e, 8'h02);
        u.glitch(6);
        ex(2'h1, 8'h9e, 8'h82);
        ex(2'h0, 8'hff, 8'hff);
        u.send(9'h03c, 8, 8, -1, 1'b1);
        ex(2'h0, 8'hff, 8'h3c);
        wr(2'h1, 8'h00);
        // Sample tick every second clock: 32 clocks per bit
        baud_div_in <= 12'h001;
        u.send(9'h0c3, 8, 32, -1, 1'b1);
        ex(2'h0, 8'hff, 8'hc3);
        @(posedge clk_in);
        baud_div_in <= 12'h000;
        $display("noise test done");
    endtask

    task automatic t_disable;
        u.send(9'h011, 8, 16, -1, 1'b1);
        fork
            u.send(9'h022, 8, 16, -1, 1'b1);
            begin
                repeat (80) @(posedge clk_in);
                wr(2'h2, 8'h00);
            end
        join
        `CHK(rx_irq_out, 1'b0)
        `CHK(rxd_override_out, 1'b0)
        ex(2'h1, 8'h9c, 8'h00);
        wr(2'h2, 8'h90);
        ex(2'h1, 8'h9c, 8'h00);
        u.send(9'h066, 8, 16, -1, 1'b1);
        ex(2'h0, 8'hff, 8'h66);
        $display("disable test done");
    endtask

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_frame;
        t_parity;
        t_overrun;
        t_ninth;
        t_noise;
        t_disable;
        summarize;
    end

    // Tests need about 5000 cycles; the limit leaves wide slack
    initial begin
        repeat (40000) @(posedge clk_in);
        failures++;
        summarize;
    end
endmodule

bind urx_receiver urx_receiver_sva #(.BAUD_DIV_W(BAUD_DIV_W)) u_sva (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .baud_div_in(baud_div_in), .rxd_in(rxd_in),
    .rxd_override_out(rxd_override_out), .rx_irq_out(rx_irq_out));

`default_nettype wire
